// file: slcd_regs.sv
// serial-written segment registers, backplane oscillator and segment drivers
`timescale 1ns/1ps
module slcd_regs #(
  parameter logic [7:0] CTRL_BYTE      = slcd_pkg::CTRL_BYTE_DEFAULT,
  parameter int         BP_HALF_CYCLES = slcd_pkg::BP_HALF_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // serial bus pins, data is open drain
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // backplane clock pin from a partner driver
  input  wire logic        backplane_in,
  // segment lines 1 to 14
  output logic [13:0]      seg_out,
  // backplane clock out or segment line fifteen
  output logic             dual_out
);

  localparam int CNT_W = $clog2(BP_HALF_CYCLES + 1);

  logic                  scl_s;
  logic                  sda_s;
  logic                  bp_in_s;
  logic                  scl_q;
  logic                  sda_q;
  slcd_pkg::slcd_state_t state;
  logic [3:0]            bit_cnt;
  logic [7:0]            shreg;
  logic [7:0]            waddr;
  slcd_pkg::slcd_lower_t lower_segment_byte;
  logic [7:0]            upper_segment_byte;
  logic [CNT_W-1:0]      osc_cnt;
  logic                  osc_clk;
  logic                  backplane_clk;
  logic [14:0]           seg_ctrl;
  logic                  segment_line_fifteen;

  // pins are asynchronous to clk_sys
  slcd_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h3) // bus lines idle high, backplane low
  ) u_sync (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .pin_in    ({backplane_in, sda_in, scl_in}),
    .level_out ({bp_in_s, sda_s, scl_s})
  );

  // bus condition decode on filtered levels
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  wire byte_end = scl_fall && (bit_cnt == slcd_pkg::BYTE_BITS);
  // a write strobe lands when the data byte completes
  wire wr_stb   = byte_end && (state == slcd_pkg::ST_DATA);

  // previous levels for edge detection
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= slcd_pkg::ST_IDLE;
    end else if (start_c) begin
      state <= slcd_pkg::ST_DEV;
    end else if (stop_c) begin
      state <= slcd_pkg::ST_IDLE;
    end else begin
      unique case (state)
        slcd_pkg::ST_IDLE: begin
          state <= slcd_pkg::ST_IDLE;
        end
        slcd_pkg::ST_DEV: begin
          // only our control byte with write direction is accepted
          if (byte_end) begin
            state <= (shreg == CTRL_BYTE) ? slcd_pkg::ST_ACK_DEV : slcd_pkg::ST_SKIP;
          end
        end
        slcd_pkg::ST_ACK_DEV: begin
          if (scl_fall) begin
            state <= slcd_pkg::ST_WADDR;
          end
        end
        slcd_pkg::ST_WADDR: begin
          if (byte_end) begin
            state <= slcd_pkg::ST_ACK_WA;
          end
        end
        slcd_pkg::ST_ACK_WA: begin
          if (scl_fall) begin
            state <= slcd_pkg::ST_DATA;
          end
        end
        slcd_pkg::ST_DATA: begin
          if (byte_end) begin
            state <= slcd_pkg::ST_ACK_DATA;
          end
        end
        slcd_pkg::ST_ACK_DATA: begin
          // one data byte per transaction; later bytes are not acknowledged
          if (scl_fall) begin
            state <= slcd_pkg::ST_SKIP;
          end
        end
        slcd_pkg::ST_SKIP: begin
          state <= slcd_pkg::ST_SKIP;
        end
      endcase
    end
  end

  // bit counter and shift register, sampled on clock rise
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
    end else if (start_c || stop_c || byte_end) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise && (state == slcd_pkg::ST_DEV || state == slcd_pkg::ST_WADDR
                              || state == slcd_pkg::ST_DATA)) begin
      bit_cnt <= bit_cnt + 4'h1;
      shreg   <= {shreg[6:0], sda_s};
    end
  end

  // word address latch
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      waddr <= 8'h00;
    end else if (byte_end && state == slcd_pkg::ST_WADDR) begin
      waddr <= shreg;
    end
  end

  // acknowledge drive: pull data low through the ack clock pulse
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else if (start_c || stop_c) begin
      sda_oe <= 1'b0;
    end else if (byte_end) begin
      sda_oe <= (state == slcd_pkg::ST_DEV) ? (shreg == CTRL_BYTE) : 1'b1;
    end else if (scl_fall) begin
      sda_oe <= 1'b0;
    end
  end

  // lower register: segments 1-7 and backplane source
  // value holds until the next write to the same address
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lower_segment_byte <= slcd_pkg::LOWER_RESET;
    end else if (wr_stb && waddr == slcd_pkg::ADDR_LOWER_SEG) begin
      lower_segment_byte <= shreg;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      upper_segment_byte <= slcd_pkg::UPPER_RESET;
    end else if (wr_stb && waddr == slcd_pkg::ADDR_UPPER_SEG) begin
      upper_segment_byte <= shreg;
    end
  end

  // internal 48 Hz oscillator, stopped and cleared unless selected
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt <= '0;
      osc_clk <= 1'b0;
    end else if (!lower_segment_byte.backplane_source_sel) begin
      osc_cnt <= '0;
      osc_clk <= 1'b0;
    end else if (osc_cnt == CNT_W'(BP_HALF_CYCLES - 1)) begin
      osc_cnt <= '0;
      osc_clk <= ~osc_clk;
    end else begin
      osc_cnt <= osc_cnt + CNT_W'(1);
    end
  end

  assign backplane_clk        = lower_segment_byte.backplane_source_sel ? osc_clk : bp_in_s;
  assign seg_ctrl             = {upper_segment_byte, lower_segment_byte.seg};
  assign segment_line_fifteen = seg_ctrl[14];

  // segment drivers, registered so pins are glitch free
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      seg_out <= 14'h0000;
    end else begin
      seg_out <= seg_ctrl[13:0] ^ {14{backplane_clk}};
    end
  end

  // dual pin: oscillator out, or line fifteen against external clock
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dual_out <= 1'b0;
    end else begin
      dual_out <= lower_segment_byte.backplane_source_sel ? osc_clk
                                                          : (segment_line_fifteen ^ bp_in_s);
    end
  end

  // assertions
  property p_seg_xor;
    @(posedge clk_sys) disable iff (!arst_n)
      1'b1 |=> seg_out == ($past(seg_ctrl[13:0]) ^ {14{$past(backplane_clk)}});
  endproperty
  a_seg_xor: assert property (p_seg_xor) else $error("segment not control xor backplane");

  property p_dual_osc;
    @(posedge clk_sys) disable iff (!arst_n)
      lower_segment_byte.backplane_source_sel |=> dual_out == $past(osc_clk);
  endproperty
  a_dual_osc: assert property (p_dual_osc) else $error("dual pin not oscillator");

  property p_dual_seg;
    @(posedge clk_sys) disable iff (!arst_n)
      !lower_segment_byte.backplane_source_sel
        |=> dual_out == ($past(upper_segment_byte[7]) ^ $past(bp_in_s));
  endproperty
  a_dual_seg: assert property (p_dual_seg) else $error("dual pin not segment fifteen");

  property p_osc_off;
    @(posedge clk_sys) disable iff (!arst_n)
      !lower_segment_byte.backplane_source_sel |=> !osc_clk && osc_cnt == '0;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator runs while deselected");

  property p_wr_lower;
    @(posedge clk_sys) disable iff (!arst_n)
      wr_stb && waddr == slcd_pkg::ADDR_LOWER_SEG |=> lower_segment_byte == $past(shreg);
  endproperty
  a_wr_lower: assert property (p_wr_lower) else $error("lower register write lost");

  property p_wr_upper;
    @(posedge clk_sys) disable iff (!arst_n)
      wr_stb && waddr == slcd_pkg::ADDR_UPPER_SEG |=> upper_segment_byte == $past(shreg);
  endproperty
  a_wr_upper: assert property (p_wr_upper) else $error("upper register write lost");

  property p_hold;
    @(posedge clk_sys) disable iff (!arst_n)
      !wr_stb |=> $stable(upper_segment_byte) && $stable(lower_segment_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without write");

  sequence s_foreign_ctrl;
    state == slcd_pkg::ST_DEV && byte_end && shreg != CTRL_BYTE;
  endsequence
  property p_foreign_nack;
    @(posedge clk_sys) disable iff (!arst_n)
      s_foreign_ctrl |=> !sda_oe && state == slcd_pkg::ST_SKIP;
  endproperty
  a_foreign_nack: assert property (p_foreign_nack) else $error("foreign control acked");

endmodule : slcd_regs

// file: slcd_pkg.sv
// shared constants and types for the static segment register block
package slcd_pkg;

  // word addresses decoded on the serial bus
  localparam logic [7:0] ADDR_LOWER_SEG = 8'hF4;
  localparam logic [7:0] ADDR_UPPER_SEG = 8'hD0;

  // control byte of this device, write direction
  localparam logic [7:0] CTRL_BYTE_DEFAULT = 8'h00;

  // source select position inside the lower segment byte and segment counts of both bytes
  localparam int SRC_SEL_BIT   = 7;
  localparam int LOWER_SEG_CNT = 7;
  localparam int UPPER_SEG_CNT = 8;
  localparam int SEG_CNT       = LOWER_SEG_CNT + UPPER_SEG_CNT;

  // values after reset
  localparam logic [7:0] LOWER_RESET = 8'h00;
  localparam logic [7:0] UPPER_RESET = 8'h00;

  // bits per byte plus the count value that marks a full byte
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // backplane timing: 48 Hz square wave from the 50 MHz system clock
  localparam int SYS_CLK_HZ      = 50_000_000;
  localparam int BACKPLANE_HZ    = 48;
  localparam int BP_HALF_CYCLES  = SYS_CLK_HZ / (2 * BACKPLANE_HZ);

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  // lower segment byte: source select plus segment lines 1 to 7
  typedef struct packed {
    logic       backplane_source_sel;
    logic [6:0] seg;
  } slcd_lower_t;

  // serial receiver states, gray along the write path
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_DEV      = 3'b001,
    ST_ACK_DEV  = 3'b011,
    ST_WADDR    = 3'b010,
    ST_ACK_WA   = 3'b110,
    ST_DATA     = 3'b111,
    ST_ACK_DATA = 3'b101,
    ST_SKIP     = 3'b100
  } slcd_state_t;

endpackage : slcd_pkg

// file: slcd_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module slcd_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  // raw pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic [slcd_pkg::SYNC_STAGES-1:0] stage;
      // first stage feeds only the second; output moves once stages two and three agree
      // reset to the idle level of the pin so no false edge follows reset
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          stage        <= {slcd_pkg::SYNC_STAGES{RESET_VAL[g]}};
          level_out[g] <= RESET_VAL[g];
        end else begin
          stage <= {stage[1:0], pin_in[g]};
          if (stage[1] == stage[2]) begin
            level_out[g] <= stage[2];
          end
        end
      end
    end
  endgenerate

endmodule : slcd_sync

// file: slcd_host_model.sv
// serial bus master model that writes the segment registers
`timescale 1ns/1ps
module slcd_host_model #(
  parameter int HALF = 10
) (
  // clock and data wire as seen by all parties
  input  wire logic clk_sys,
  input  wire logic sda_wire,
  // bus drive, data high means released
  output logic      scl,
  output logic      sda_drv
);
  // both lines idle high from time zero
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // one bus phase, lines change just after a falling edge
  task automatic phase(input logic c, input logic d);
    scl = c;
    sda_drv = d;
    repeat (HALF) @(negedge clk_sys);
  endtask : phase

  // start, three bytes, stop
  // data held a phase after scl falls so no false start or stop
  task automatic write_cmd(input logic [7:0] c, input logic [7:0] a,
                           input logic [7:0] v, output logic [2:0] ack);
    logic [23:0] frame;
    frame = {c, a, v};
    phase(1'b1, 1'b1);
    phase(1'b1, 1'b0);
    phase(1'b0, 1'b0);
    for (int i = 23; i >= 0; i--) begin
      phase(1'b0, frame[i]);
      phase(1'b1, frame[i]);
      phase(1'b0, frame[i]);
      if (i % 8 == 0) begin
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b1);
        ack[i/8] = ~sda_wire;
        phase(1'b0, 1'b1);
      end
    end
    phase(1'b0, 1'b0);
    phase(1'b1, 1'b0);
    phase(1'b1, 1'b1);
  endtask : write_cmd
endmodule : slcd_host_model

// file: tb_static_lcd_segment_regs_i2c.sv
// self-checking bench for two segment register devices on one bus
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module tb_static_lcd_segment_regs_i2c;
  localparam int HALF_BP = 20;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        bp = 1'b0;
  logic        scl;
  logic        sda_drv;
  logic [13:0] seg_out [2];
  logic        dual_out [2];
  logic        sda_oe [2];
  logic        sda_out [2];
  logic [2:0]  ack;
  logic [7:0]  lo [2] = '{8'h00, 8'h00};
  logic [7:0]  hi [2] = '{8'h00, 8'h00};
  logic [7:0]  rc;
  logic [7:0]  ra;
  logic        p;
  int          n;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          seed = 32'h0000_c3af;
  // open drain wire: an enabled device drives its data value, else it is released
  wire         sda_wire = sda_drv & (sda_oe[0] ? sda_out[0] : 1'b1)
                                  & (sda_oe[1] ? sda_out[1] : 1'b1);

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  // device one at control byte 00, device two at 10
  for (genvar g = 0; g < 2; g++) begin : dev
    slcd_regs #(
      .CTRL_BYTE      (g ? 8'h10 : 8'h00),
      .BP_HALF_CYCLES (HALF_BP)
    ) slcd_regs_i (
      .clk_sys      (clk_sys),
      .arst_n       (arst_n),
      .scl_in       (scl),
      .sda_in       (sda_wire),
      .sda_out      (sda_out[g]),
      .sda_oe       (sda_oe[g]),
      .backplane_in (bp),
      .seg_out      (seg_out[g]),
      .dual_out     (dual_out[g])
    );
  end

  slcd_host_model slcd_host_model_i (
    .clk_sys  (clk_sys),
    .sda_wire (sda_wire),
    .scl      (scl),
    .sda_drv  (sda_drv)
  );

  // verdict and end of run
  task automatic complete_run();
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      complete_run();
    end
  end

  // bus write plus model update; only a matching device answers
  task automatic wr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] v);
    int d;
    d = (c == 8'h00) ? 0 : (c == 8'h10) ? 1 : -1;
    slcd_host_model_i.write_cmd(c, a, v, ack);
    `CHK(ack, (d < 0) ? 3'b000 : 3'b111)
    if (d >= 0 && a == slcd_pkg::ADDR_LOWER_SEG) lo[d] = v;
    if (d >= 0 && a == slcd_pkg::ADDR_UPPER_SEG) hi[d] = v;
  endtask : wr

  // compare outputs once synchronisers settle; avoid oscillator edges
  task automatic check();
    logic [13:0] bits;
    for (int d = 0; d < 2; d++) begin
      repeat (8) @(negedge clk_sys);
      bits = {hi[d][6:0], lo[d][6:0]};
      if (lo[d][7]) begin
        p = dual_out[d];
        repeat (3) @(negedge clk_sys);
        if (dual_out[d] !== p) repeat (6) @(negedge clk_sys);
        `CHK(seg_out[d] ^ {14{dual_out[d]}}, bits)
      end else begin
        `CHK(seg_out[d], bits ^ {14{bp}})
        `CHK(dual_out[d], hi[d][7] ^ bp)
      end
    end
  endtask : check

  initial begin
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    check();
    // all-segments pattern, four writes
    wr(8'h00, 8'hF4, 8'hFF);
    wr(8'h00, 8'hD0, 8'h7F);
    wr(8'h10, 8'hF4, 8'hFF);
    wr(8'h10, 8'hD0, 8'hFF);
    check();
    // internal oscillator half period seen on the dual pin
    p = dual_out[0];
    while (dual_out[0] === p) @(negedge clk_sys);
    p = dual_out[0];
    n = 0;
    while (dual_out[0] === p) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(n, HALF_BP)
    // digit codes joined by bitwise or, colon on the second device
    wr(8'h00, 8'hF4, 8'h8D | 8'hB0);
    wr(8'h00, 8'hD0, 8'h30 | 8'h03);
    wr(8'h10, 8'hF4, 8'h07 | 8'h78);
    wr(8'h10, 8'hD0, 8'hB8 | 8'h07 | 8'h40);
    check();
    // foreign control byte, read bit and unmapped word address
    wr(8'h20, 8'hF4, 8'h00);
    wr(8'h01, 8'hD0, 8'h00);
    wr(8'h00, 8'h55, 8'hAA);
    check();
    // random traffic with a random backplane level
    repeat (8) begin
      bp = 1'($random(seed));
      rc = ($random(seed) & 1) ? 8'h10 : 8'h00;
      ra = ($random(seed) & 1) ? 8'hF4 : 8'hD0;
      wr(rc, ra, 8'($random(seed)));
      check();
    end
    // reset in mid-run clears both registers
    arst_n = 1'b0;
    @(negedge clk_sys);
    `CHK({seg_out[0], seg_out[1], dual_out[0], dual_out[1]}, 30'h0000_0000)
    lo = '{8'h00, 8'h00};
    hi = '{8'h00, 8'h00};
    repeat (2) @(negedge clk_sys);
    arst_n = 1'b1;
    check();
    // bus still works after the second reset
    wr(8'h10, 8'hD0, 8'h5A);
    check();
    complete_run();
  end
endmodule : tb_static_lcd_segment_regs_i2c
